/* File: logic/seq_consts.svh */
// Purpose: Shared constants of the instruction sequencer
// Assumes: Included by its bare name
// Notes: Offsets, field positions, vectors and phase counts
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define PC_W 12
`define INSN_W 15
`define DATA_W 8
`define STK_DEPTH 4
`define IRQ_N 6
`define PH_FETCH 2'h0
`define PH_LAST 2'h3
`define VEC_RESET 12'h000
`define VEC_INT0 12'h004
`define VEC_INT1 12'h008
`define VEC_CNT0 12'h00c
`define VEC_CNT1 12'h010
`define VEC_TBASE 12'h014
`define VEC_CLOCK 12'h018
`define REG_PC_LOW 2'h0
`define REG_ACC 2'h1
`define REG_STATUS 2'h2
`define ST_C 0
`define ST_AC 1
`define ST_Z 2
`define ST_OV 3
`endif

/* File: logic/seq_pkg.sv */
// Purpose: Types of the instruction sequencer
// Assumes: Nothing
// Notes: Instruction word is class[14:12], field[11:0]
package seq_pkg;
	typedef enum logic [2:0] {
		CL_ALU_A,
		CL_ALU_P,
		CL_JMP,
		CL_CALL,
		CL_RETURN,
		CL_RETURN_IRQ,
		CL_SKZ,
		CL_SKNZ
	} iclass_e;
	typedef enum logic [3:0] {
		ALU_ADD,
		ALU_ADC,
		ALU_SUB,
		ALU_SBC,
		ALU_DECIMAL_ADJUST,
		ALU_AND,
		ALU_OR,
		ALU_XOR,
		ALU_CPL,
		ALU_RR,
		ALU_RRC,
		ALU_RL,
		ALU_RLC,
		ALU_INC,
		ALU_DEC,
		ALU_MOV
	} alu_op_e;
endpackage

/* File: logic/alu8.sv */
// Purpose: Eight bit ALU with status update
// Assumes: Purely combinational
// Notes: Carry is not-borrow on subtract
`timescale 1ns/1ps
`include "seq_consts.svh"
module alu8
	import seq_pkg::*;
(
	// Operands
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire alu_op_e op,
	// Status
	input wire logic [3:0] st_in,
	output logic [7:0] res,
	output logic [3:0] st_out
);
	logic [7:0] bb;
	logic ci;
	logic [8:0] sum;
	logic [4:0] half;
	logic [8:0] adj;
	always_comb
	begin
		bb = b;
		ci = 1'b0;
		if (op == ALU_SUB || op == ALU_SBC)
			bb = ~b;
		if (op == ALU_SUB)
			ci = 1'b1;
		else if (op == ALU_ADC || op == ALU_SBC)
			ci = st_in[`ST_C];
		sum = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		adj = {1'b0, a};
		if (a[3:0] > 4'h9 || st_in[`ST_AC])
			adj = adj + 9'h006;
		if (adj[8:4] > 5'h09 || st_in[`ST_C])
			adj = adj + 9'h060;
		res = a;
		st_out = st_in;
		unique case (op)
			ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC:
			begin
				res = sum[7:0];
				st_out[`ST_C] = sum[8];
				st_out[`ST_AC] = half[4];
				st_out[`ST_OV] = (a[7] == bb[7]) && (sum[7] != a[7]);
			end
			ALU_DECIMAL_ADJUST:
			begin
				res = adj[7:0];
				st_out[`ST_C] = adj[8] | st_in[`ST_C];
			end
			ALU_AND: res = a & b;
			ALU_OR: res = a | b;
			ALU_XOR: res = a ^ b;
			ALU_CPL: res = ~a;
			ALU_RR: res = {a[0], a[7:1]};
			ALU_RRC:
			begin
				res = {st_in[`ST_C], a[7:1]};
				st_out[`ST_C] = a[0];
			end
			ALU_RL: res = {a[6:0], a[7]};
			ALU_RLC:
			begin
				res = {a[6:0], st_in[`ST_C]};
				st_out[`ST_C] = a[7];
			end
			ALU_INC: res = a + 8'h01;
			ALU_DEC: res = a - 8'h01;
			ALU_MOV: res = b;
		endcase
		if (!(op inside {ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_MOV}))
			st_out[`ST_Z] = (res == 8'h00);
	end
endmodule // alu8

/* File: logic/instruction_sequencer.sv */
// Purpose: Four-phase instruction sequencer, program counter, return stack
// Assumes: Program memory answers combinationally on pm_addr
// Notes: Instruction word is class[14:12], operand or target[11:0]
// Overview of operation
// - The clock is split into four phases; four phases make one cycle.
// - Counter increments at phase one while the next word is fetched.
// - Fetch overlaps execute; jumps and calls take two cycles.
// - A taken skip discards the prefetched word and inserts a dummy cycle.
// - The program counter is twelve bits wide.
// - Reset loads zero; each interrupt source loads its own fixed vector.
// - Writing the low counter byte keeps the upper bits and inserts a dummy.
// - Jumps and calls load all twelve counter bits from the word.
// - Returns restore all twelve counter bits from the stack.
// - Four-entry stack holds counter values only and is not software visible.
// - Every call and interrupt acknowledge pushes the counter less one.
// - After reset the stack index points at entry zero, the first level a push fills.
// - With the stack full interrupts wait until a return frees a level.
// - A call with the stack full still executes and overflows.
// - Only the low counter byte is readable and writable by software.
// - The ALU writes its destination and updates the status flags.
// - ALU offers add, subtract, decimal adjust, logic, rotates, inc, dec.
// - The datapath is eight bits wide through the accumulator.
`timescale 1ns/1ps
`include "seq_consts.svh"
module instruction_sequencer
	import seq_pkg::*;
#(
	parameter int STK_DEPTH = `STK_DEPTH
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Program memory
	output logic [`PC_W-1:0] pm_addr,
	input wire logic [`INSN_W-1:0] pm_data,
	// Interrupts
	input wire logic [`IRQ_N-1:0] irq_req,
	output logic irq_ack,
	output logic [2:0] irq_ack_id,
	output logic irq_return,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [`DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`DATA_W-1:0] reg_rdata,
	// Sequencer state
	output logic [1:0] cycle_phases,
	output logic dummy_cycle,
	output logic stack_full
);
	localparam int IW = $clog2(STK_DEPTH);
	localparam logic [`IRQ_N-1:0][`PC_W-1:0] VEC = {
		`VEC_CLOCK, `VEC_TBASE, `VEC_CNT1, `VEC_CNT0, `VEC_INT1, `VEC_INT0
	};

	typedef struct packed {
		logic [1:0] ph;
		logic [`PC_W-1:0] pc;
		logic [`INSN_W-1:0] fetch;
		logic [`INSN_W-1:0] exec;
		logic exec_v;
		logic flush;
		logic [STK_DEPTH-1:0][`PC_W-1:0] stk;
		logic [IW-1:0] idx;
		logic [IW:0] cnt;
		logic [`DATA_W-1:0] acc;
		logic [3:0] status;
		logic [`DATA_W-1:0] rdata;
		logic ack;
		logic [2:0] ack_id;
		logic iret;
	} seq_s;

	seq_s st_q;
	seq_s st_d;
	iclass_e cls;
	logic exec_now;
	logic full;
	logic redir;
	logic pc_wr;
	logic irq_hit;
	logic [2:0] irq_id;
	logic push_en;
	logic pop_en;
	logic [`PC_W-1:0] push_val;
	logic [`PC_W-1:0] top;
	logic [`PC_W-1:0] ret_addr;
	logic [`DATA_W-1:0] alu_a;
	logic [`DATA_W-1:0] alu_res;
	logic [3:0] alu_st;

	assign cls = iclass_e'(st_q.exec[14:12]);
	assign exec_now = (st_q.ph == `PH_LAST) && st_q.exec_v;
	assign full = (st_q.cnt == (IW+1)'(STK_DEPTH));
	assign top = st_q.stk[IW'(st_q.idx - IW'(1))];
	// The prefetched word sits one behind the incremented counter
	assign ret_addr = st_q.pc - `PC_W'(1);
	assign alu_a = (cls == CL_ALU_P) ? st_q.pc[7:0] : st_q.acc;

	alu8 u_alu (
		.a(alu_a),
		.b(st_q.exec[7:0]),
		.op(alu_op_e'(st_q.exec[11:8])),
		.st_in(st_q.status),
		.res(alu_res),
		.st_out(alu_st)
	);

	always_comb
	begin
		st_d = st_q;
		redir = 1'b0;
		push_en = 1'b0;
		pop_en = 1'b0;
		push_val = ret_addr;
		irq_hit = 1'b0;
		irq_id = 3'h0;
		pc_wr = reg_wr && (reg_addr == `REG_PC_LOW);
		st_d.ph = st_q.ph + 2'h1;
		st_d.ack = 1'b0;
		st_d.iret = 1'b0;
		st_d.rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				`REG_PC_LOW: st_d.rdata = st_q.pc[7:0];
				`REG_ACC: st_d.rdata = st_q.acc;
				`REG_STATUS: st_d.rdata = {3'h0, full, st_q.status};
				default: st_d.rdata = '0;
			endcase
		end
		if (st_q.ph == `PH_FETCH)
		begin
			st_d.pc = st_q.pc + `PC_W'(1);
			st_d.fetch = pm_data;
		end
		if (pc_wr)
		begin
			st_d.pc = {st_q.pc[11:8], reg_wdata};
			st_d.flush = 1'b1;
		end
		if (reg_wr && reg_addr == `REG_ACC)
			st_d.acc = reg_wdata;
		if (exec_now)
		begin
			unique case (cls)
				CL_ALU_A:
				begin
					st_d.acc = alu_res;
					st_d.status = alu_st;
				end
				CL_ALU_P:
				begin
					st_d.pc = {st_q.pc[11:8], alu_res};
					st_d.status = alu_st;
					redir = 1'b1;
				end
				CL_JMP:
				begin
					st_d.pc = st_q.exec[11:0];
					redir = 1'b1;
				end
				CL_CALL:
				begin
					push_en = 1'b1;
					st_d.pc = st_q.exec[11:0];
					redir = 1'b1;
				end
				CL_RETURN, CL_RETURN_IRQ:
				begin
					pop_en = 1'b1;
					st_d.pc = top;
					st_d.iret = (cls == CL_RETURN_IRQ);
					redir = 1'b1;
				end
				CL_SKZ:
					redir = (st_q.acc == '0);
				CL_SKNZ:
					redir = (st_q.acc != '0);
			endcase
		end
		// Entry waits for a cycle with no redirect, so the pushed address
		// names a word that has not executed yet
		if (st_q.ph == `PH_LAST && !redir && !pc_wr && !st_q.flush && !full)
		begin
			for (int i = `IRQ_N - 1; i >= 0; i--)
			begin
				if (irq_req[i])
				begin
					irq_hit = 1'b1;
					irq_id = 3'(i);
				end
			end
		end
		if (irq_hit)
		begin
			push_en = 1'b1;
			st_d.pc = VEC[irq_id];
			st_d.ack = 1'b1;
			st_d.ack_id = irq_id;
			redir = 1'b1;
		end
		// A push with the stack full wraps the index over the oldest entry
		if (push_en)
		begin
			st_d.stk[st_q.idx] = push_val;
			st_d.idx = st_q.idx + IW'(1);
			if (!full)
				st_d.cnt = st_q.cnt + (IW+1)'(1);
		end
		if (pop_en)
		begin
			st_d.idx = st_q.idx - IW'(1);
			if (st_q.cnt != '0)
				st_d.cnt = st_q.cnt - (IW+1)'(1);
		end
		if (st_q.ph == `PH_LAST)
		begin
			st_d.exec = st_q.fetch;
			st_d.exec_v = !(redir || pc_wr || st_q.flush);
			st_d.flush = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			st_q <= '0;
			st_q.pc <= `VEC_RESET;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign pm_addr = st_q.pc;
	assign irq_ack = st_q.ack;
	assign irq_ack_id = st_q.ack_id;
	assign irq_return = st_q.iret;
	assign reg_rdata = st_q.rdata;
	assign cycle_phases = st_q.ph;
	assign dummy_cycle = !st_q.exec_v;
	assign stack_full = full;

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	AST_PHASE_ORDER: assert property (
		st_q.ph == `PH_LAST |=> st_q.ph == `PH_FETCH ##1 st_q.ph == 2'h1
	) else $error("Phase sequence broken");

	AST_PC_INCREMENT: assert property (
		(st_q.ph == `PH_FETCH && !pc_wr) |=> st_q.pc == $past(st_q.pc) + `PC_W'(1)
	) else $error("Counter did not advance at phase one");

	AST_FETCH_OVERLAP: assert property (
		st_q.ph == `PH_FETCH |=> st_q.fetch == $past(pm_data) ##3 st_q.exec == $past(pm_data, 4)
	) else $error("Fetched word not handed to execute");

	AST_SKIP_DUMMY: assert property (
		(exec_now && cls == CL_SKZ && st_q.acc == '0) |=> dummy_cycle [*4]
	) else $error("Taken skip did not insert a dummy cycle");

	AST_PC_LOW_PAGE: assert property (
		(exec_now && cls == CL_ALU_P)
		|=> st_q.pc[11:8] == $past(st_q.pc[11:8]) && dummy_cycle
	) else $error("Low byte write left the page or skipped the dummy");

	AST_JUMP_TARGET: assert property (
		(exec_now && cls == CL_JMP) |=> st_q.pc == $past(st_q.exec[11:0]) && dummy_cycle
	) else $error("Jump target not loaded");

	AST_CALL_PUSH: assert property (
		(exec_now && cls == CL_CALL)
		|=> top == $past(ret_addr) && st_q.pc == $past(st_q.exec[11:0])
	) else $error("Call did not push the return address");

	AST_RETURN_POP: assert property (
		(exec_now && cls inside {CL_RETURN, CL_RETURN_IRQ}) |=> st_q.pc == $past(top)
	) else $error("Return did not restore the counter");

	AST_FULL_NO_ACK: assert property (
		full |=> !irq_ack
	) else $error("Interrupt acknowledged with the stack full");

	AST_ACK_VECTOR: assert property (
		irq_ack |-> st_q.pc == VEC[irq_ack_id] && top == $past(ret_addr)
	) else $error("Interrupt vector or saved address wrong");

	AST_ACK_TWO_CYCLES: assert property (
		irq_ack |-> dummy_cycle [*4] ##1 (st_q.exec == $past(pm_data, 4) || dummy_cycle)
	) else $error("Interrupt entry did not take a dummy cycle");

	AST_RESET_STATE: assert property (
		disable iff (1'b0)
		!rst_b |=> st_q.pc == `VEC_RESET && st_q.ph == `PH_FETCH
			&& st_q.cnt == '0 && st_q.idx == '0
	) else $error("Reset did not clear counter, phase or stack index");

	AST_IRET_PULSE: assert property (
		(exec_now && cls == CL_RETURN_IRQ) |=> irq_return ##1 !irq_return
	) else $error("Interrupt return pulse wrong");

	AST_ACK_PULSE: assert property (
		irq_ack |=> !irq_ack
	) else $error("Acknowledge longer than one cycle");

	AST_ACK_PUSH: assert property (
		irq_hit |=> st_q.cnt == $past(st_q.cnt) + (IW+1)'(1)
	) else $error("Interrupt entry did not fill a stack level");

	AST_POP_COUNT: assert property (
		(exec_now && cls inside {CL_RETURN, CL_RETURN_IRQ} && st_q.cnt != '0)
		|=> st_q.cnt == $past(st_q.cnt) - (IW+1)'(1)
	) else $error("Return did not free a stack level");

	AST_RDATA_IDLE: assert property (
		!reg_rd |=> reg_rdata == '0
	) else $error("Read data outside its cycle");

	AST_PC_LOW_READ: assert property (
		(reg_rd && reg_addr == `REG_PC_LOW) |=> reg_rdata == $past(st_q.pc[7:0])
	) else $error("Low counter byte read wrong");

	AST_STACK_HIDDEN: assert property (
		(reg_rd && reg_addr == 2'h3) |=> reg_rdata == '0
	) else $error("Unmapped read returned data");

	AST_STATUS_RO: assert property (
		(reg_wr && reg_addr == `REG_STATUS && !exec_now)
		|=> st_q.status == $past(st_q.status)
	) else $error("Status changed by a bus write");

	AST_ACC_WRITE: assert property (
		(reg_wr && reg_addr == `REG_ACC && !exec_now) |=> st_q.acc == $past(reg_wdata)
	) else $error("Accumulator write lost");

	CVR_CALL: cover property (exec_now && cls == CL_CALL);
	CVR_IRQ_ACK: cover property (irq_ack);
	CVR_SKIP: cover property (exec_now && cls == CL_SKZ && st_q.acc == '0);
	CVR_FULL_WAIT: cover property (full && |irq_req ##4 !full ##[1:8] irq_ack);
endmodule // instruction_sequencer

/* File: dv/prog_mem.sv */
// Purpose: Program memory model feeding instruction words
// Assumes: Combinational answer on the address, as the sequencer expects
// Notes: Contents are loaded by the bench before reset ends
`timescale 1ns/1ps
module prog_mem
(
	// Fetch port
	input wire logic [11:0] addr,
	output logic [14:0] data
);
	logic [14:0] mem [0:4095];
	// Drives the word stored at the address, undefined where none was loaded
	assign data = mem[addr];
endmodule // prog_mem

/* File: dv/instruction_sequencer_pc_stack_tb.sv */
// Purpose: Self-checking bench of the instruction sequencer
// Assumes: Program placed in the memory model at time zero
// Notes: Pipeline, skip, call, interrupts, full stack and registers
`timescale 1ns/1ps
module instruction_sequencer_pc_stack_tb;
	logic clock = 0;
	logic rst_b = 0;
	logic [11:0] pm_addr;
	logic [14:0] pm_data;
	logic [5:0] irq_req = 0;
	logic irq_ack, irq_return, dummy_cycle, stack_full;
	logic [2:0] irq_ack_id;
	logic [1:0] reg_addr = 0, cycle_phases, ph;
	logic [7:0] reg_wdata = 0, reg_rdata, d;
	logic reg_wr = 0, reg_rd = 0;
	int fail_count = 0, check_count = 0;
	always #5 clock = ~clock;
	prog_mem pm (.addr(pm_addr), .data(pm_data));
	instruction_sequencer dut (.clock(clock), .rst_b(rst_b), .pm_addr(pm_addr),
		.pm_data(pm_data), .irq_req(irq_req), .irq_ack(irq_ack), .irq_ack_id(irq_ack_id),
		.irq_return(irq_return), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cycle_phases(cycle_phases), .dummy_cycle(dummy_cycle), .stack_full(stack_full));
	task finish_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_wr <= 0;
	endtask
	task rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 0;
		#1 v = reg_rdata;
	endtask
	// Waits for a fetch address or an acknowledge, bounded
	task wait_for(input logic [11:0] a, input bit ack, input int n);
		int i;
		for (i = 0; i < n; i++)
		begin
			@(posedge clock);
			#1;
			if (ack ? (irq_ack === 1'b1) : (pm_addr === a))
				break;
		end
		chk(i < n, 1);
	endtask
	initial
	begin
		#200000;
		fail_count++;
		finish_test();
	end
	initial
	begin
		for (int i = 0; i < 4096; i++)
			pm.mem[i] = 15'h0000;
		pm.mem[12'h000] = {3'h2, 12'h020};
		pm.mem[12'h020] = {3'h0, 4'hf, 8'h5a};
		pm.mem[12'h021] = {3'h0, 4'h0, 8'ha6};
		pm.mem[12'h022] = {3'h6, 12'h000};
		pm.mem[12'h023] = {3'h0, 4'hf, 8'hff};
		pm.mem[12'h024] = {3'h3, 12'h100};
		pm.mem[12'h025] = {3'h1, 4'hf, 8'h40};
		pm.mem[12'h040] = {3'h2, 12'h040};
		pm.mem[12'h041] = {3'h2, 12'h040};
		pm.mem[12'h100] = {3'h4, 12'h000};
		for (int i = 1; i <= 6; i++)
			pm.mem[i * 4] = {3'h5, 12'h000};
		pm.mem[12'h060] = {3'h3, 12'h070};
		pm.mem[12'h070] = {3'h3, 12'h080};
		pm.mem[12'h080] = {3'h3, 12'h090};
		pm.mem[12'h090] = {3'h3, 12'h0a0};
		pm.mem[12'h0a0] = {3'h2, 12'h0a0};
		pm.mem[12'h0b0] = {3'h4, 12'h000};
		pm.mem[12'h091] = {3'h2, 12'h091};
		pm.mem[12'h092] = {3'h2, 12'h091};
		repeat (12) @(posedge clock);
		rst_b <= 1;
		@(posedge clock);
		#1 chk(pm_addr, 12'h001);
		wait_for(12'h100, 0, 80);
		wait_for(12'h040, 0, 80);
		rd(2'h1, d);
		chk(d, 8'h00);
		rd(2'h2, d);
		chk(d, 8'h07);
		wr(2'h2, 8'hff);
		rd(2'h2, d);
		chk(d, 8'h07);
		wr(2'h1, 8'h33);
		rd(2'h1, d);
		chk(d, 8'h33);
		rd(2'h3, d);
		chk(d, 8'h00);
		rd(2'h0, d);
		chk(d, 8'h42);
		@(posedge clock);
		#1 chk(reg_rdata, 8'h00);
		ph = cycle_phases;
		repeat (4) @(posedge clock);
		#1 chk(cycle_phases, ph);
		@(posedge clock);
		#1 chk(cycle_phases, ph + 2'h1);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clock);
			irq_req[i] <= 1;
			wait_for(0, 1, 40);
			chk(irq_ack_id, i);
			chk(pm_addr, 4 * (i + 1));
			@(posedge clock);
			irq_req <= 0;
			wait_for(12'h040, 0, 80);
			chk(irq_return, 1);
		end
		wr(2'h0, 8'h60);
		wait_for(12'h0a0, 0, 80);
		#1 chk(stack_full, 1);
		@(posedge clock);
		irq_req[1] <= 1;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge clock);
			#1 chk(irq_ack, 0);
		end
		wr(2'h0, 8'hb0);
		wait_for(0, 1, 60);
		chk(irq_ack_id, 3'h1);
		chk(pm_addr, 12'h008);
		@(posedge clock);
		irq_req <= 0;
		wait_for(12'h091, 0, 80);
		@(posedge clock);
		rst_b <= 0;
		@(posedge clock);
		@(posedge clock);
		#1 chk(pm_addr, 12'h000);
		chk(stack_full, 0);
		chk(dummy_cycle, 1);
		@(posedge clock);
		rst_b <= 1;
		repeat (2) @(posedge clock);
		#1 chk(pm_addr, 12'h001);
		finish_test();
	end
endmodule // instruction_sequencer_pc_stack_tb
